// file: core/qpr_pkg.sv
// Package of constants and types for the quad potentiometer register map.
package qpr_pkg;
   // ==================================================
   // Address map
   localparam logic [3:0] ADDR_WIPER0 = 4'h0;
   localparam logic [3:0] ADDR_WIPER1 = 4'h1;
   localparam logic [3:0] ADDR_TCTRL_A = 4'h4;
   localparam logic [3:0] ADDR_WIPER2 = 4'h6;
   localparam logic [3:0] ADDR_WIPER3 = 4'h7;
   localparam logic [3:0] ADDR_TCTRL_B = 4'hA;
   // ==================================================
   // Field positions and reset values
   localparam int TOP_BIT_POS = 8;
   localparam int ODD_NIB_POS = 4;
   localparam int EVEN_NIB_POS = 0;
   localparam int FORCE_POS = 3;
   localparam int TERM_A_POS = 2;
   localparam int WIPER_POS = 1;
   localparam int TERM_B_POS = 0;
   localparam logic [8:0] TCTRL_RESET = 9'h1FF;
   localparam logic [8:0] MID_8BIT = 9'h080;
   localparam logic [8:0] MID_7BIT = 9'h040;
   localparam logic [8:0] FULL_8BIT = 9'h100;
   localparam logic [8:0] FULL_7BIT = 9'h080;
   localparam logic [8:0] ZERO_SCALE = 9'h000;
   // ==================================================
   // Commands
   typedef enum logic [1:0] {
      QPR_CMD_WRITE = 2'b00,
      QPR_CMD_INC = 2'b01,
      QPR_CMD_DEC = 2'b10,
      QPR_CMD_READ = 2'b11
   } qpr_cmd_t;
   typedef struct packed {
      qpr_cmd_t cmd;
      logic [3:0] addr;
      logic [8:0] data;
   } qpr_req_t;
   typedef struct packed {
      logic term_a;
      logic wiper;
      logic term_b;
   } qpr_sw_t;
endpackage

// file: core/qpr_regs.sv
// Register map of the four-channel potentiometer with terminal switch outputs.
`timescale 1ns/1ps
// Function
// - Sixteen nine-bit locations, implemented ones volatile only.
// - Wipers at 00h, 01h, 06h, 07h accept read, write, increment, decrement.
// - Terminal control at 04h and 0Ah accept only read and write.
// - Any command to a reserved address raises the command error.
// - Increment or decrement on terminal control is an error, register unchanged.
// - Error holds until chip select goes inactive then active again.
// - Reset loads wipers with mid scale, 80h or 40h by resolution.
// - Reset loads both terminal control registers with 1FFh.
// - Bits 7..4 serve odd channel, bits 3..0 the even channel.
// - Bit 8 of terminal control reads 1 and ignores writes.
// - Nibble top bit at 0 forces the channel into shutdown.
// - Lower three bits connect terminal A, wiper, terminal B when 1.
// - Written terminal control reaches switches only after command completes.
// - Terminal control writes never alter wiper registers.
// - In shutdown A is disconnected and wiper tied to terminal B.
// - Shutdown keeps stored bits; releasing it restores their control.
// - Wiper above full scale drives full at the output; increment or decrement there is ignored.
// - Decrement at zero is ignored.
module qpr_regs #(
   parameter bit EIGHT_BIT = 1'b1
) (
   input wire logic sys_clk, // System clock, 250 MHz.
   input wire logic reset, // Asynchronous reset, power-up or reset pin.
   input wire logic cs_n_pin, // Chip select from host, asynchronous.
   input wire logic req_valid, // Decoded command pulse from the serial front end.
   input wire qpr_pkg::qpr_req_t req, // Command, address and write data.
   input wire logic frame_done, // Pulse when the serial command has completed.
   output logic [8:0] rd_data, // Read data, registered.
   output logic cmd_error, // Command error condition, level.
   output logic [35:0] wiper_out, // Four wiper values, channel 0 low.
   output logic [3:0] shutdown_force_n, // Per channel shutdown release.
   output qpr_pkg::qpr_sw_t [3:0] sw_out // Effective terminal switches.
);
   // ==================================================
   // Chip select synchroniser
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= cs_n_pin;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
      end
   end
   wire cs_fall = cs_s3_q & ~cs_s2_q;

   // ==================================================
   // Decode
   localparam logic [8:0] MID_VAL = EIGHT_BIT ? qpr_pkg::MID_8BIT : qpr_pkg::MID_7BIT;
   wire [8:0] full_val = EIGHT_BIT ? qpr_pkg::FULL_8BIT : qpr_pkg::FULL_7BIT;
   wire hit_w0 = req.addr == qpr_pkg::ADDR_WIPER0;
   wire hit_w1 = req.addr == qpr_pkg::ADDR_WIPER1;
   wire hit_w2 = req.addr == qpr_pkg::ADDR_WIPER2;
   wire hit_w3 = req.addr == qpr_pkg::ADDR_WIPER3;
   wire hit_ta = req.addr == qpr_pkg::ADDR_TCTRL_A;
   wire hit_tb = req.addr == qpr_pkg::ADDR_TCTRL_B;
   wire [3:0] hit_w = {hit_w3, hit_w2, hit_w1, hit_w0};
   wire hit_t = hit_ta | hit_tb;
   wire is_step = (req.cmd == qpr_pkg::QPR_CMD_INC) | (req.cmd == qpr_pkg::QPR_CMD_DEC);
   wire bad_cmd = ~(|hit_w) & ~hit_t | hit_t & is_step;
   // Commands are not executed while the error holds.
   wire go = req_valid & ~cmd_error & ~bad_cmd;

   // ==================================================
   // Error condition
   // A new error wins over the chip select cycle that clears it.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_error <= 1'b0;
      end else if (req_valid & bad_cmd) begin
         cmd_error <= 1'b1;
      end else if (cs_fall) begin
         cmd_error <= 1'b0;
      end
   end

   // ==================================================
   // Wiper registers
   logic [8:0] wiper_q [4];
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_wiper
         wire sel = go & hit_w[g];
         wire at_full = wiper_q[g] >= full_val;
         logic [8:0] wiper_d;
         always_comb begin
            wiper_d = wiper_q[g];
            if (sel) begin
               case (req.cmd)
                  qpr_pkg::QPR_CMD_WRITE: wiper_d = req.data;
                  qpr_pkg::QPR_CMD_INC: if (!at_full) wiper_d = wiper_q[g] + 9'h001;
                  qpr_pkg::QPR_CMD_DEC: begin
                     // Exactly full scale may still step down; only values above it freeze.
                     if (wiper_q[g] <= full_val && wiper_q[g] != qpr_pkg::ZERO_SCALE) begin
                        wiper_d = wiper_q[g] - 9'h001;
                     end
                  end
                  default: wiper_d = wiper_q[g];
               endcase
            end
         end
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               wiper_q[g] <= MID_VAL;
            end else begin
               wiper_q[g] <= wiper_d;
            end
         end
         assign wiper_out[g*9 +: 9] = at_full ? full_val : wiper_q[g];
      end
   endgenerate

   // ==================================================
   // Terminal control: staged during a command, applied when it completes
   logic [7:0] tctl_a_q, tctl_b_q, stage_a_q, stage_b_q;
   logic pend_q;
   wire wr_ta = go & hit_ta & (req.cmd == qpr_pkg::QPR_CMD_WRITE);
   wire wr_tb = go & hit_tb & (req.cmd == qpr_pkg::QPR_CMD_WRITE);
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stage_a_q <= qpr_pkg::TCTRL_RESET[7:0];
         stage_b_q <= qpr_pkg::TCTRL_RESET[7:0];
         tctl_a_q <= qpr_pkg::TCTRL_RESET[7:0];
         tctl_b_q <= qpr_pkg::TCTRL_RESET[7:0];
         pend_q <= 1'b0;
      end else begin
         if (wr_ta) stage_a_q <= req.data[7:0];
         if (wr_tb) stage_b_q <= req.data[7:0];
         pend_q <= (pend_q | wr_ta | wr_tb) & ~frame_done;
         if (frame_done) begin
            tctl_a_q <= wr_ta ? req.data[7:0] : stage_a_q;
            tctl_b_q <= wr_tb ? req.data[7:0] : stage_b_q;
         end
      end
   end

   // ==================================================
   // Read path
   wire [8:0] ta_rd = {1'b1, stage_a_q};
   wire [8:0] tb_rd = {1'b1, stage_b_q};
   wire [8:0] rd_mux = hit_w0 ? wiper_q[0] : hit_w1 ? wiper_q[1] : hit_w2 ? wiper_q[2] :
                       hit_w3 ? wiper_q[3] : hit_ta ? ta_rd : hit_tb ? tb_rd : 9'h000;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_data <= 9'h000;
      end else if (go & (req.cmd == qpr_pkg::QPR_CMD_READ)) begin
         rd_data <= rd_mux;
      end
   end

   // ==================================================
   // Terminal switch outputs
   wire [15:0] tctl_all = {tctl_b_q, tctl_a_q};
   generate
      for (g = 0; g < 4; g++) begin : g_sw
         wire [3:0] nib = tctl_all[g*4 +: 4];
         assign shutdown_force_n[g] = nib[qpr_pkg::FORCE_POS];
         // Shutdown overrides but never rewrites the stored bits.
         assign sw_out[g].term_a = nib[qpr_pkg::FORCE_POS] & nib[qpr_pkg::TERM_A_POS];
         assign sw_out[g].wiper = ~nib[qpr_pkg::FORCE_POS] | nib[qpr_pkg::WIPER_POS];
         assign sw_out[g].term_b = ~nib[qpr_pkg::FORCE_POS] | nib[qpr_pkg::TERM_B_POS];
      end
   endgenerate

   // ==================================================
   // Assertions
   // Properties using |=> look at registered state and trail their cause by one edge; the |-> output checks hold in the same cycle.

   // ==================================================
   // Error condition
   a_err_set: assert property (
      @(posedge sys_clk) disable iff (reset)
      req_valid && bad_cmd |=> cmd_error)
      else $error("error not raised");
   a_err_hold: assert property (
      @(posedge sys_clk) disable iff (reset)
      cmd_error && !cs_fall |=> cmd_error)
      else $error("error dropped early");
   a_err_clear: assert property (
      @(posedge sys_clk) disable iff (reset)
      cmd_error && cs_fall && !(req_valid && bad_cmd) |=> !cmd_error)
      else $error("error not cleared");
   a_err_quiet: assert property (
      @(posedge sys_clk) disable iff (reset)
      !cmd_error && !(req_valid && bad_cmd) |=> !cmd_error)
      else $error("error raised without cause");
   a_err_block: assert property (
      @(posedge sys_clk) disable iff (reset)
      cmd_error |=> $stable(wiper_q[1]) && $stable(wiper_q[2]))
      else $error("command ran during error");
   a_tctl_step: assert property (
      @(posedge sys_clk) disable iff (reset)
      req_valid && hit_t && is_step |=> $stable(stage_a_q) && $stable(stage_b_q))
      else $error("step changed terminal control");

   // ==================================================
   // Wiper arithmetic
   a_inc_one: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w0 && req.cmd == qpr_pkg::QPR_CMD_INC && wiper_q[0] < full_val
      |=> wiper_q[0] == $past(wiper_q[0]) + 9'h001)
      else $error("increment wrong");
   a_dec_one: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w2 && req.cmd == qpr_pkg::QPR_CMD_DEC && wiper_q[2] != 9'h000 &&
      wiper_q[2] <= full_val |=> wiper_q[2] == $past(wiper_q[2]) - 9'h001)
      else $error("decrement wrong");
   a_dec_zero: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w0 && req.cmd == qpr_pkg::QPR_CMD_DEC && wiper_q[0] == 9'h000
      |=> wiper_q[0] == 9'h000)
      else $error("decrement below zero");
   a_inc_full: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w1 && req.cmd == qpr_pkg::QPR_CMD_INC && wiper_q[1] >= full_val
      |=> $stable(wiper_q[1]))
      else $error("increment past full");
   a_dec_full: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w1 && req.cmd == qpr_pkg::QPR_CMD_DEC && wiper_q[1] == full_val
      |=> wiper_q[1] == full_val - 9'h001)
      else $error("decrement from full lost");
   a_dec_above: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w3 && req.cmd == qpr_pkg::QPR_CMD_DEC && wiper_q[3] > full_val
      |=> $stable(wiper_q[3]))
      else $error("decrement above full");
   a_full_out: assert property (
      @(posedge sys_clk) disable iff (reset)
      wiper_q[1] >= full_val |-> wiper_out[17:9] == full_val)
      else $error("wiper output not clamped");
   a_below_out: assert property (
      @(posedge sys_clk) disable iff (reset)
      wiper_q[1] < full_val |-> wiper_out[17:9] == wiper_q[1])
      else $error("wiper output wrong");
   a_write_wiper: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w3 && req.cmd == qpr_pkg::QPR_CMD_WRITE |=> wiper_q[3] == $past(req.data))
      else $error("wiper write lost");
   a_wiper_keep: assert property (
      @(posedge sys_clk) disable iff (reset)
      req_valid && hit_t |=> $stable(wiper_q[0]) && $stable(wiper_q[3]))
      else $error("terminal write hit wiper");

   // ==================================================
   // Terminal control
   a_tctl_late: assert property (
      @(posedge sys_clk) disable iff (reset)
      !frame_done |=> $stable(tctl_a_q) && $stable(tctl_b_q))
      else $error("switches changed mid command");
   a_tctl_apply: assert property (
      @(posedge sys_clk) disable iff (reset)
      frame_done && !wr_ta |=> tctl_a_q == $past(stage_a_q))
      else $error("staged value not applied");
   a_pend_track: assert property (
      @(posedge sys_clk) disable iff (reset)
      (wr_ta || wr_tb) && !frame_done |=> pend_q)
      else $error("pending write not tracked");
   a_stage_write: assert property (
      @(posedge sys_clk) disable iff (reset)
      wr_tb |=> stage_b_q == $past(req.data[7:0]))
      else $error("terminal write lost");

   // ==================================================
   // Read path
   a_read_top: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_ta && req.cmd == qpr_pkg::QPR_CMD_READ |=> rd_data[8])
      else $error("top bit not one");
   a_read_wiper: assert property (
      @(posedge sys_clk) disable iff (reset)
      go && hit_w0 && req.cmd == qpr_pkg::QPR_CMD_READ |=> rd_data == $past(wiper_q[0]))
      else $error("wiper read wrong");
   a_rsv_read: assert property (
      @(posedge sys_clk) disable iff (reset)
      req_valid && bad_cmd |=> $stable(rd_data))
      else $error("reserved read gave data");
   a_rd_hold: assert property (
      @(posedge sys_clk) disable iff (reset)
      !(go && req.cmd == qpr_pkg::QPR_CMD_READ) |=> $stable(rd_data))
      else $error("read data moved");

   // ==================================================
   // Switch outputs
   a_shut_state: assert property (
      @(posedge sys_clk) disable iff (reset)
      !shutdown_force_n[0] |-> !sw_out[0].term_a && sw_out[0].wiper && sw_out[0].term_b)
      else $error("shutdown state wrong");
   a_shut_ch3: assert property (
      @(posedge sys_clk) disable iff (reset)
      !shutdown_force_n[3] |-> sw_out[3] == 3'b011)
      else $error("channel three shutdown wrong");
   a_live_ch1: assert property (
      @(posedge sys_clk) disable iff (reset)
      shutdown_force_n[1] |-> sw_out[1] == tctl_a_q[6:4])
      else $error("stored bits not in control");

   // ==================================================
   // Covers
   c_error: cover property (@(posedge sys_clk) cmd_error ##[1:50] !cmd_error);
   c_tctl: cover property (@(posedge sys_clk) wr_ta ##[0:40] frame_done);
   c_shut: cover property (@(posedge sys_clk) !shutdown_force_n[2]);
   c_dec_full: cover property (@(posedge sys_clk)
      go && hit_w1 && req.cmd == qpr_pkg::QPR_CMD_DEC && wiper_q[1] == full_val);
endmodule

// file: testbench/qpr_host_model.sv
// Host model that sends decoded commands with completion pulses and cycles chip select on request.
`timescale 1ns/1ps
module qpr_host_model (
   input wire logic sys_clk, // System clock.
   output logic req_valid, // Command strobe.
   output qpr_pkg::qpr_req_t req, // Command word.
   output logic frame_done, // End of serial command.
   output logic cs_n_pin // Chip select, active low.
);
   initial begin
      req_valid = 1'b0;
      req = '0;
      frame_done = 1'b0;
      cs_n_pin = 1'b1;
   end
   // ==================================================
   // One command, then its completion pulse unless held back.
   task automatic send(input qpr_pkg::qpr_cmd_t c, input logic [3:0] a, input logic [8:0] d,
                       input bit fin);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= qpr_pkg::qpr_req_t'({c, a, d});
      @(posedge sys_clk);
      req_valid <= 1'b0;
      // Released lines must not keep showing the old word.
      req <= qpr_pkg::qpr_req_t'(~{c, a, d});
      frame_done <= fin;
      @(posedge sys_clk);
      frame_done <= 1'b0;
   endtask
   // Chip select goes inactive and active again; long enough for the synchroniser.
   task automatic cs_cycle();
      cs_n_pin <= 1'b1;
      repeat (16) @(posedge sys_clk);
      cs_n_pin <= 1'b0;
      repeat (16) @(posedge sys_clk);
   endtask
endmodule

// file: testbench/qpr_regs_tb_top.sv
// Self-checking bench for the quad potentiometer register map.
`timescale 1ns/1ps
module qpr_regs_tb_top;
   localparam qpr_pkg::qpr_cmd_t WR = qpr_pkg::QPR_CMD_WRITE;
   localparam qpr_pkg::qpr_cmd_t INC = qpr_pkg::QPR_CMD_INC;
   localparam qpr_pkg::qpr_cmd_t DEC = qpr_pkg::QPR_CMD_DEC;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid, frame_done, cs_n_pin, cmd_error;
   logic rd_pend = 1'b0;
   qpr_pkg::qpr_req_t req;
   logic [8:0] rd_data;
   logic [35:0] wiper_out;
   logic [3:0] shutdown_force_n;
   qpr_pkg::qpr_sw_t [3:0] sw_out;
   logic [8:0] exp_q[$];
   logic [8:0] wv[4];
   logic [3:0] addrs[6] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'hA};
   logic [3:0] ra;
   logic [31:0] lfsr = 32'h3b71_0c50;
   int fails = 0;
   int checks_done = 0;
   always #2 sys_clk = ~sys_clk;
   qpr_regs #(.EIGHT_BIT(1'b1)) i_qpr_regs (.sys_clk(sys_clk), .reset(reset),
      .cs_n_pin(cs_n_pin), .req_valid(req_valid), .req(req), .frame_done(frame_done),
      .rd_data(rd_data), .cmd_error(cmd_error), .wiper_out(wiper_out),
      .shutdown_force_n(shutdown_force_n), .sw_out(sw_out));
   qpr_host_model i_qpr_host_model (.sys_clk(sys_clk), .req_valid(req_valid), .req(req),
      .frame_done(frame_done), .cs_n_pin(cs_n_pin));
   // ==================================================
   // Helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic cmd(input qpr_pkg::qpr_cmd_t c, input logic [3:0] a, input logic [8:0] d);
      i_qpr_host_model.send(c, a, d, 1'b1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [8:0] e);
      exp_q.push_back(e);
      cmd(qpr_pkg::QPR_CMD_READ, a, 9'h000);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==================================================
   // Read monitor: each accepted read to a mapped place consumes the oldest note.
   always @(posedge sys_clk) begin
      rd_pend <= req_valid && req.cmd == qpr_pkg::QPR_CMD_READ && !cmd_error &&
                 (req.addr inside {4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'hA});
   end
   always @(negedge sys_clk) begin
      if (rd_pend) check(rd_data, exp_q.pop_front(), "read data");
   end
   initial begin
      #100_000;
      fails++;
      complete_run();
   end
   // ==================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      i_qpr_host_model.cs_cycle();
      foreach (addrs[i]) rd(addrs[i], (addrs[i] inside {4'h4, 4'hA}) ? 9'h1FF : 9'h080);
      check({shutdown_force_n, sw_out}, {4'hF, 12'hFFF}, "reset switches");
      cmd(WR, 4'hA, 9'h1FF);
      i_qpr_host_model.send(WR, 4'h4, 9'h0F7, 1'b0);
      @(negedge sys_clk);
      check({shutdown_force_n, sw_out}, {4'hF, 12'hFFF}, "applied early");
      rd(4'h4, 9'h1F7);
      @(negedge sys_clk);
      check({shutdown_force_n[1:0], sw_out[0].term_a, sw_out[1]}, 6'b100111, "ch0 off");
      cmd(WR, 4'h4, 9'h05D);
      cmd(WR, 4'hA, 9'h03C);
      @(negedge sys_clk);
      check({shutdown_force_n, sw_out[0], sw_out[2]}, {4'b0101, 6'b101100}, "nibbles");
      check(wiper_out, {4{9'h080}}, "wipers kept");
      cmd(WR, 4'h1, 9'h0FF); cmd(INC, 4'h1, 9'h000); rd(4'h1, 9'h100);
      cmd(INC, 4'h1, 9'h000); rd(4'h1, 9'h100);
      cmd(DEC, 4'h1, 9'h000); rd(4'h1, 9'h0FF);
      cmd(WR, 4'h1, 9'h000); cmd(DEC, 4'h1, 9'h000); rd(4'h1, 9'h000);
      cmd(WR, 4'h7, 9'h1FF); cmd(DEC, 4'h7, 9'h000);
      @(negedge sys_clk);
      check(wiper_out[35:27], 9'h100, "above full");
      foreach (wv[g]) begin
         lfsr = lfsr_next(lfsr);
         wv[g] = {1'b0, lfsr[7:0]};
         cmd(WR, addrs[g + (g > 1)], wv[g]);
         rd(addrs[g + (g > 1)], wv[g]);
      end
      check(wiper_out, {wv[3], wv[2], wv[1], wv[0]}, "wiper outputs");
      cmd(INC, 4'h4, 9'h000);
      @(negedge sys_clk);
      check(cmd_error, 1'b1, "tctrl step");
      i_qpr_host_model.cs_cycle();
      rd(4'h4, 9'h15D);
      for (int a = 0; a < 16; a++) begin
         ra = 4'(a);
         if (!(ra inside {addrs})) begin
            lfsr = lfsr_next(lfsr);
            cmd(qpr_pkg::qpr_cmd_t'(lfsr[1:0]), ra, lfsr[8:0]);
            cmd(WR, 4'h0, 9'h000);
            @(negedge sys_clk);
            check({cmd_error, wiper_out[8:0]}, {1'b1, wv[0]}, "reserved");
            i_qpr_host_model.cs_cycle();
            check(cmd_error, 1'b0, "error cleared");
         end
      end
      repeat (2) @(posedge sys_clk);
      check(exp_q.size(), 0, "reads left over");
      complete_run();
   end
endmodule
